// *** verilog/kmh_params.svh ***
// How it works
// RL1: polarity clear gives standard interrupt polarity
// RL2: polarity set inverts hardware host interrupts
// RL3: host read at 64 returns status
// RL4: status register clears to zero on reset
// RL5: data-out write sets output-full flag
// RL6: host read at 60 clears output-full
// RL7: host write at 60/64 sets input-full
// RL8: core data-in read clears input-full
// RL9: status bit 2 is firmware flag
// RL10: bit 3 captures host address bit two
// RL11: bits 7..4 are firmware status flags
// RL12: core status write keeps hardware bits
// RL13: keyboard data-out write raises keyboard interrupt
// RL14: mouse data-out write raises mouse interrupt
// RL15: data-out write drops core out-empty interrupt
// RL16: data-in read drops core in-full interrupt
// RL17: level mode follows output-full flag
// RL18: pulse mode idles high, pulses low
// RL19: both data-out registers share one buffer
`ifndef KMH_PARAMS_SVH
`define KMH_PARAMS_SVH
`define KMH_OFS_STATUS 16'hfea4
`define KMH_OFS_KBD_OUT 16'hfea6
`define KMH_OFS_MOUSE_OUT 16'hfea8
`define KMH_OFS_DATA_IN 16'hfeaa
`define KMH_STATUS_RESET 8'h00
`define KMH_BIT_OBF 0
`define KMH_BIT_IBF 1
`define KMH_BIT_F0 2
`define KMH_BIT_A2 3
`define KMH_FW_MASK 8'hf4
`define KMH_MODE_LEVEL 3'h0
`endif

// *** verilog/kmh_pkg.sv ***
package kmh_pkg;
   typedef struct packed {
      logic rd;
      logic wr;
      logic a2;
      logic [7:0] wdata;
   } kmh_host_req_t;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } kmh_core_req_t;
   typedef struct packed {
      logic invert;
      logic [2:0] mode;
      logic kbd_en;
      logic mouse_en;
      logic obe_cie;
      logic ibf_cie;
   } kmh_ctrl_t;
endpackage : kmh_pkg

// *** verilog/kmh_irq_shaper.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "kmh_params.svh"
// one host interrupt line: level follows output-full, pulse mode emits low pulse
module kmh_irq_shaper (
   input wire logic clock,
   input wire logic rst,
   input wire logic enable,
   input wire logic invert,
   input wire logic [2:0] mode,
   input wire logic fire,
   input wire logic output_full_flag,
   output logic irq
);
   import kmh_pkg::*;
   typedef struct packed {
      logic [4:0] cnt;
      logic lvl;
   } kmh_shp_st_t;
   kmh_shp_st_t st_r, st_nxt;

   function automatic logic [4:0] kmh_width(input logic [2:0] m);
      unique case (m)
         3'h1: kmh_width = 5'h01;
         3'h2: kmh_width = 5'h02;
         3'h3: kmh_width = 5'h04;
         3'h4: kmh_width = 5'h08;
         3'h5: kmh_width = 5'h10;
         default: kmh_width = 5'h01;
      endcase
   endfunction : kmh_width

   always_comb begin
      st_nxt = st_r;
      // RL17 level tracks flag
      st_nxt.lvl = enable & output_full_flag;
      // RL18 pulse on fire
      if (fire && enable && mode != `KMH_MODE_LEVEL) begin
         st_nxt.cnt = kmh_width(mode);
      end else if (st_r.cnt != 5'h00) begin
         st_nxt.cnt = st_r.cnt - 5'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   logic raw;
   // RL1 standard polarity
   assign raw = (mode == `KMH_MODE_LEVEL) ? st_r.lvl : ~(st_r.cnt != 5'h00);
   // RL2 invert when enabled
   assign irq = (enable & invert) ? ~raw : raw;

   // RL18
   a_pulse_low_width: assert property (@(posedge clock) disable iff (rst)
      (enable && !invert && mode == 3'h1 && fire) |=> !irq ##1 irq)
      else $error("one-cycle pulse wrong");
   // RL17
   a_level_follows: assert property (@(posedge clock) disable iff (rst)
      (enable && !invert && mode == 3'h0) ##1 (!invert && mode == 3'h0)
      |-> (irq == $past(output_full_flag)))
      else $error("level irq not following flag");
endmodule : kmh_irq_shaper
`default_nettype wire

// *** verilog/kmh_sync2.sv ***
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pin-level host strobes
module kmh_sync2 #(
   parameter int W = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   always_ff @(posedge clock) begin
      if (rst) begin
         s1_r <= '0;
         q <= '0;
      end else begin
         s1_r <= d;
         q <= s1_r;
      end
   end
endmodule : kmh_sync2
`default_nettype wire

// *** verilog/kmh_mailbox.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "kmh_params.svh"
module kmh_mailbox (
   input wire logic clock,
   input wire logic rst,
   input wire kmh_pkg::kmh_host_req_t host_req,
   output logic [7:0] host_rdata,
   input wire kmh_pkg::kmh_core_req_t core_req,
   output logic [7:0] core_rdata,
   input wire kmh_pkg::kmh_ctrl_t ctrl,
   output logic keyboard_host_interrupt,
   output logic mouse_host_interrupt,
   output logic core_out_empty_irq,
   output logic core_in_full_irq
);
   import kmh_pkg::*;

   // ------------------------------------------------------------
   // host strobes come from another clock, so edge detect after sync
   // ------------------------------------------------------------
   // host data goes through the same two flops, so it is never read mid-change
   logic [10:0] hs;
   logic [1:0] hs_d_r;
   kmh_sync2 #(.W(11)) u_sync (
      .clock(clock),
      .rst(rst),
      .d({host_req.rd, host_req.wr, host_req.a2, host_req.wdata}),
      .q(hs)
   );
   logic h_rd, h_wr, h_a2;
   logic [7:0] h_wdata;
   assign h_rd = hs[10] & ~hs_d_r[1];
   assign h_wr = hs[9] & ~hs_d_r[0];
   assign h_a2 = hs[8];
   assign h_wdata = hs[7:0];

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] out_buf;
      logic [7:0] in_buf;
      logic [7:0] host_rdata;
      logic [7:0] core_rdata;
      logic kfire;
      logic mfire;
      logic obe_irq;
      logic ibf_irq;
   } kmh_st_t;
   kmh_st_t st_r, st_nxt;

   logic c_st_wr, c_kbd_wr, c_mouse_wr, c_in_rd, c_st_rd;
   assign c_st_wr = core_req.wr && core_req.addr == `KMH_OFS_STATUS;
   assign c_kbd_wr = core_req.wr && core_req.addr == `KMH_OFS_KBD_OUT;
   assign c_mouse_wr = core_req.wr && core_req.addr == `KMH_OFS_MOUSE_OUT;
   assign c_in_rd = core_req.rd && core_req.addr == `KMH_OFS_DATA_IN;
   assign c_st_rd = core_req.rd && core_req.addr == `KMH_OFS_STATUS;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.kfire = 1'b0;
      st_nxt.mfire = 1'b0;
      // RL12 firmware bits only
      if (c_st_wr) begin
         st_nxt.status = (st_r.status & ~`KMH_FW_MASK) | (core_req.wdata & `KMH_FW_MASK);
      end
      // RL6 host data read
      if (h_rd && !h_a2) begin
         st_nxt.status[`KMH_BIT_OBF] = 1'b0;
      end
      // RL19 shared output buffer
      if (c_kbd_wr || c_mouse_wr) begin
         st_nxt.out_buf = core_req.wdata;
         // RL5 set wins over clear
         st_nxt.status[`KMH_BIT_OBF] = 1'b1;
         // RL15 drop out-empty irq
         if (ctrl.obe_cie) begin
            st_nxt.obe_irq = 1'b0;
         end
      end
      // RL13 keyboard fire
      st_nxt.kfire = c_kbd_wr;
      // RL14 mouse fire
      st_nxt.mfire = c_mouse_wr;
      // RL8 core read clears
      if (c_in_rd) begin
         st_nxt.core_rdata = st_r.in_buf;
         st_nxt.status[`KMH_BIT_IBF] = 1'b0;
         // RL16 drop in-full irq
         if (ctrl.ibf_cie) begin
            st_nxt.ibf_irq = 1'b0;
         end
      end else if (c_st_rd) begin
         st_nxt.core_rdata = st_r.status;
      end
      // RL7 host write, set wins
      if (h_wr) begin
         st_nxt.in_buf = h_wdata;
         st_nxt.status[`KMH_BIT_IBF] = 1'b1;
         // RL10 capture address bit
         st_nxt.status[`KMH_BIT_A2] = h_a2;
         st_nxt.ibf_irq = ctrl.ibf_cie;
      end
      if (h_rd && !h_a2 && !(c_kbd_wr || c_mouse_wr)) begin
         st_nxt.obe_irq = ctrl.obe_cie;
      end
      // RL3 status at 64, data at 60
      if (h_rd) begin
         st_nxt.host_rdata = h_a2 ? st_r.status : st_r.out_buf;
      end
   end

   always_ff @(posedge clock) begin
      // RL4 status clears
      if (rst) begin
         st_r <= '0;
         hs_d_r <= '0;
      end else begin
         st_r <= st_nxt;
         hs_d_r <= hs[10:9];
      end
   end

   // RL9 RL11 firmware flags readable at host and core
   assign host_rdata = st_r.host_rdata;
   assign core_rdata = st_r.core_rdata;
   assign core_out_empty_irq = st_r.obe_irq;
   assign core_in_full_irq = st_r.ibf_irq;

   // ------------------------------------------------------------
   // host interrupt lines
   // ------------------------------------------------------------
   // RL13 keyboard line
   kmh_irq_shaper u_kirq (
      .clock(clock),
      .rst(rst),
      .enable(ctrl.kbd_en),
      .invert(ctrl.invert),
      .mode(ctrl.mode),
      .fire(st_r.kfire),
      .output_full_flag(st_r.status[`KMH_BIT_OBF]),
      .irq(keyboard_host_interrupt)
   );
   // RL14 mouse line
   kmh_irq_shaper u_mirq (
      .clock(clock),
      .rst(rst),
      .enable(ctrl.mouse_en),
      .invert(ctrl.invert),
      .mode(ctrl.mode),
      .fire(st_r.mfire),
      .output_full_flag(st_r.status[`KMH_BIT_OBF]),
      .irq(mouse_host_interrupt)
   );

   a_obf_set: assert property (@(posedge clock) disable iff (rst)
      (c_kbd_wr || c_mouse_wr) |=> st_r.status[0]) // RL5
      else $error("output-full not set");
   a_obf_clear: assert property (@(posedge clock) disable iff (rst)
      (h_rd && !h_a2 && !c_kbd_wr && !c_mouse_wr) |=> !st_r.status[0]) // RL6
      else $error("output-full not cleared");
   a_ibf_set: assert property (@(posedge clock) disable iff (rst)
      h_wr |=> st_r.status[1] && st_r.status[3] == $past(h_a2)) // RL7
      else $error("input-full or a2 wrong");
   a_ibf_clear: assert property (@(posedge clock) disable iff (rst)
      (c_in_rd && !h_wr) |=> !st_r.status[1]) // RL8
      else $error("input-full not cleared");
   a_hw_bits_kept: assert property (@(posedge clock) disable iff (rst)
      (c_st_wr && !h_wr && !h_rd && !c_kbd_wr && !c_mouse_wr && !c_in_rd)
      |=> st_r.status[3] == $past(st_r.status[3])
      && st_r.status[1:0] == $past(st_r.status[1:0])) // RL12
      else $error("hw bits changed");
   a_fw_flags: assert property (@(posedge clock) disable iff (rst)
      (c_st_wr && !h_wr) |=> (st_r.status & 8'hf4) == ($past(core_req.wdata) & 8'hf4)) // RL11
      else $error("firmware flags not written");
   a_status_read: assert property (@(posedge clock) disable iff (rst)
      (h_rd && h_a2) |=> host_rdata == $past(st_r.status)) // RL3
      else $error("status read wrong");
   a_obe_drop: assert property (@(posedge clock) disable iff (rst)
      ((c_kbd_wr || c_mouse_wr) && ctrl.obe_cie) |=> !core_out_empty_irq) // RL15
      else $error("out-empty irq not dropped");
   a_ibf_drop: assert property (@(posedge clock) disable iff (rst)
      (c_in_rd && ctrl.ibf_cie && !h_wr) |=> !core_in_full_irq) // RL16
      else $error("in-full irq not dropped");
endmodule : kmh_mailbox
`default_nettype wire

// *** tb/kmh_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------
// host side: pin-level strobes
// -------------------------------------
module kmh_host_model (
   input wire logic clock,
   output var kmh_pkg::kmh_host_req_t host_req,
   input wire logic [7:0] host_rdata
);
   import kmh_pkg::*;
   initial host_req = '0;
   // strobe held past the sync and edge detect, then a gap so the next edge is seen
   task automatic access(input logic wr, input logic a2, input logic [7:0] d,
                         output logic [7:0] q);
      @(negedge clock);
      host_req = '{rd: !wr, wr: wr, a2: a2, wdata: d};
      repeat (5) @(negedge clock);
      q = host_rdata;
      host_req.rd = 1'b0;
      host_req.wr = 1'b0;
      // released data no longer carries the byte
      host_req.wdata = ~d;
      repeat (3) @(negedge clock);
   endtask : access
endmodule : kmh_host_model
`default_nettype wire

// *** tb/kbd_mouse_host_mailbox_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "kmh_params.svh"
module kbd_mouse_host_mailbox_test;
   import kmh_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   kmh_host_req_t host_req;
   kmh_core_req_t core_req = '0;
   kmh_ctrl_t ctrl = '0;
   logic [7:0] host_rdata, core_rdata, q, d1, d2, f;
   logic kirq, mirq, oe_irq, if_irq, a2;
   int failures = 0;
   int samples_checked = 0;
   int m, cnt;
   always #5 clock = ~clock;
   kmh_host_model u_host (.clock(clock), .host_req(host_req), .host_rdata(host_rdata));
   kmh_mailbox u_dut (.clock(clock), .rst(rst), .host_req(host_req),
      .host_rdata(host_rdata), .core_req(core_req), .core_rdata(core_rdata),
      .ctrl(ctrl), .keyboard_host_interrupt(kirq), .mouse_host_interrupt(mirq),
      .core_out_empty_irq(oe_irq), .core_in_full_irq(if_irq));
   // -------------------------------------
   // helpers
   // -------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic core_wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clock);
      core_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge clock);
      core_req.wr = 1'b0;
   endtask : core_wr
   task automatic core_rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge clock);
      core_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge clock);
      core_req.rd = 1'b0;
      @(negedge clock);
      d = core_rdata;
   endtask : core_rd
   // cycles the active level is seen in a 24-cycle window
   function automatic logic [7:0] pulse_len(input int md);
      return (md == 0) ? 8'h18 : 8'(1 << (md - 1));
   endfunction : pulse_len
   task automatic results();
      if (failures == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   // -------------------------------------
   // tests
   // -------------------------------------
   initial begin
      void'($urandom(32'h8699));
      ctrl = '{invert: 1'b0, mode: 3'h0, kbd_en: 1'b1, mouse_en: 1'b1,
               obe_cie: 1'b1, ibf_cie: 1'b1};
      repeat (8) @(negedge clock);
      rst = 1'b0;
      core_rd(`KMH_OFS_STATUS, q);
      chk(q, `KMH_STATUS_RESET);
      u_host.access(1'b0, 1'b1, 8'h00, q);
      chk(q, `KMH_STATUS_RESET);
      for (int k = 0; k < 8; k++) begin
         d1 = $urandom;
         d2 = $urandom;
         core_wr(`KMH_OFS_KBD_OUT, d1);
         core_wr(`KMH_OFS_MOUSE_OUT, d2);
         chk({7'h0, oe_irq}, 8'h00);
         core_rd(`KMH_OFS_STATUS, q);
         chk(q & 8'h03, 8'h01);
         u_host.access(1'b0, 1'b0, 8'h00, q);
         chk(q, d2);
         core_rd(`KMH_OFS_STATUS, q);
         chk(q & 8'h03, 8'h00);
         a2 = k[0];
         u_host.access(1'b1, a2, d1, q);
         core_rd(`KMH_OFS_STATUS, q);
         chk(q & 8'h0b, {4'h0, a2, 3'h2});
         chk({7'h0, if_irq}, 8'h01);
         core_rd(`KMH_OFS_DATA_IN, q);
         chk(q, d1);
         chk({7'h0, if_irq}, 8'h00);
         core_rd(`KMH_OFS_STATUS, q);
         chk(q & 8'h02, 8'h00);
         f = $urandom;
         core_wr(`KMH_OFS_STATUS, f);
         // unmapped address must leave the status alone
         core_wr(16'hfea2, ~f);
         u_host.access(1'b0, 1'b1, 8'h00, q);
         chk(q, (f & `KMH_FW_MASK) | {4'h0, a2, 3'h0});
      end
      for (int i = 0; i < 12; i++) begin
         m = i % 6;
         ctrl.invert = (i >= 6);
         ctrl.mode = 3'(m);
         ctrl.kbd_en = 1'($urandom);
         ctrl.mouse_en = !ctrl.kbd_en;
         repeat (4) @(negedge clock);
         core_wr(ctrl.kbd_en ? `KMH_OFS_KBD_OUT : `KMH_OFS_MOUSE_OUT, 8'(i));
         cnt = 0;
         repeat (24) begin
            @(negedge clock);
            cnt += ((ctrl.kbd_en ? kirq : mirq) === ((m == 0) ^ ctrl.invert));
         end
         chk(8'(cnt), pulse_len(m));
         u_host.access(1'b0, 1'b0, 8'h00, q);
         chk({7'h0, ctrl.kbd_en ? kirq : mirq}, {7'h0, !((m == 0) ^ ctrl.invert)});
      end
      results();
   end
   // a hang is cut off well past the expected run length
   initial begin
      #200000;
      failures++;
      results();
   end
endmodule : kbd_mouse_host_mailbox_test
`default_nettype wire
